// *** hw/adcdb_pkg.sv ***
// Shared constants for the converter control and diagnostic block
package adcdb_pkg;

  // Clock and precharge timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          PRE_FAST_NS   = 15;
  localparam int          PRE_MED_NS    = 29;
  localparam int          PRE_LOW_NS    = 116;
  localparam logic [5:0]  PRE_FAST_CYC  = 6'((PRE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0]  PRE_MED_CYC   = 6'((PRE_MED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0]  PRE_LOW_CYC   = 6'((PRE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register offsets
  localparam logic [6:0]  ADDR_POWER_CLOCK = 7'h04;
  localparam logic [6:0]  ADDR_SYNC        = 7'h06;
  localparam logic [6:0]  ADDR_SELF_TEST   = 7'h08;
  localparam logic [6:0]  ADDR_STATUS      = 7'h09;
  localparam logic [6:0]  ADDR_REVISION    = 7'h0a;
  localparam logic [6:0]  ADDR_DIAG_RX     = 7'h0b;
  localparam logic [6:0]  ADDR_DIAG_CTL    = 7'h0c;
  localparam logic [6:0]  ADDR_GPIO_DIR    = 7'h0d;
  localparam logic [6:0]  ADDR_GPIO_OUT    = 7'h0e;
  localparam logic [6:0]  ADDR_GPIO_IN     = 7'h0f;
  localparam logic [6:0]  ADDR_BUF_LOW     = 7'h11;
  localparam logic [6:0]  ADDR_BUF_HIGH    = 7'h12;
  localparam logic [3:0]  ADDR_OFFS_BASE   = 4'h4;
  localparam logic [3:0]  ADDR_GAIN_BASE   = 4'h5;

  // Field positions and codes
  localparam int          PWR_LSB       = 4;
  localparam int          SYNC_BIT      = 7;
  localparam int          ST_START_BIT  = 0;
  localparam int          DIAG_EN_BIT   = 7;
  localparam logic [1:0]  PWR_LOW       = 2'h0;
  localparam logic [1:0]  PWR_MED       = 2'h2;
  localparam logic [1:0]  PWR_FAST      = 2'h3;
  localparam logic [1:0]  DIV_CODE_4    = 2'h0;
  localparam logic [1:0]  DIV_CODE_8    = 2'h1;
  localparam logic [1:0]  DIV_CODE_32   = 2'h3;
  localparam logic [1:0]  DIAG_POS_FS   = 2'h1;
  localparam logic [1:0]  DIAG_MID      = 2'h2;
  localparam logic [5:0]  MOD_DIV_MIN   = 6'h04;

  // Reset values; the identification value is arbitrary
  localparam logic [7:0]  POWER_CLOCK_RST = 8'h30;
  localparam logic [7:0]  BUF_EN_RST      = 8'hff;
  localparam logic [7:0]  GAIN_UNITY      = 8'h80;
  localparam logic [7:0]  REVISION_ID     = 8'h5c;

  // Data path
  localparam logic [4:0]  DECIM_LAST   = 5'h1f;
  localparam logic [1:0]  SETTLE_WORDS = 2'h2;
  localparam int          FILT_SHIFT   = 18;
  localparam int          GAIN_SHIFT   = 7;
  localparam int          OFFS_SHIFT   = 8;
  localparam logic [23:0] CODE_POS_FS  = 24'h7fffff;
  localparam logic [23:0] CODE_NEG_FS  = 24'h800000;
  localparam logic [3:0]  BIST_LAST    = 4'hf;
  localparam logic [7:0]  BIST_PATTERN = 8'ha5;

endpackage : adcdb_pkg

// *** hw/adcdb_mod_timer.sv ***
// Modulator clock divider, sampling ticks and precharge window
`timescale 1ns/10ps
module adcdb_mod_timer
  import adcdb_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_div_code,
  input  wire logic [1:0] i_pwr_mode,
  output logic            o_mod_tick,
  output logic            o_sample_tick,
  output logic            o_mod_phase,
  output logic            o_precharge_win
);

  logic [5:0] cnt;
  wire  [5:0] div_len = 6'(MOD_DIV_MIN << i_div_code);
  wire  [5:0] half    = div_len >> 1;
  wire        wrap    = (cnt >= div_len - 6'h01);
  wire  [5:0] win_len = (i_pwr_mode == PWR_FAST) ? PRE_FAST_CYC :
                        (i_pwr_mode == PWR_MED)  ? PRE_MED_CYC  : PRE_LOW_CYC;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      cnt <= 6'h00;
    else
      cnt <= wrap ? 6'h00 : cnt + 6'h01;
  end

  assign o_mod_tick      = (cnt == 6'h00);
  // Two samples per modulator cycle
  assign o_sample_tick   = (cnt == 6'h00) || (cnt == half); // RQ15
  assign o_mod_phase     = (cnt < half);
  // Early part of every modulator cycle
  assign o_precharge_win = (cnt < win_len); // RQ16

endmodule : adcdb_mod_timer

// *** hw/adcdb_channel.sv ***
// One channel: decimating filter, gain and offset, saturation
`timescale 1ns/10ps
module adcdb_channel
  import adcdb_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic              i_mod_tick,
  input  wire logic              i_mod_bit,
  input  wire logic              i_sync,
  input  wire logic              i_run,
  input  wire logic        [7:0] i_gain,
  input  wire logic signed [7:0] i_offset,
  output logic            [23:0] o_data,
  output logic                   o_valid
);

  logic signed [6:0]  acc;
  logic        [4:0]  cnt;
  logic        [1:0]  settle;
  wire  signed [6:0]  acc_next = acc + (i_mod_bit ? 7'sh01 : 7'sh7f);
  wire  signed [31:0] filt     = 32'(acc_next) <<< FILT_SHIFT;
  wire  signed [40:0] prod     = filt * $signed({1'b0, i_gain});
  wire  signed [40:0] sum      = (prod >>> GAIN_SHIFT) + (41'(i_offset) <<< OFFS_SHIFT); // RQ9
  wire                in_range = (sum[40:23] == {18{sum[40]}});
  wire         [23:0] result   = in_range ? sum[23:0] : (sum[40] ? CODE_NEG_FS : CODE_POS_FS); // RQ12
  wire                word_end = i_mod_tick && (cnt == DECIM_LAST);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || i_sync || !i_run)
    begin
      acc     <= 7'sh00;
      cnt     <= 5'h00;
      settle  <= (i_rst || i_sync) ? 2'h0 : settle; // RQ23
      o_valid <= 1'b0;
      o_data  <= i_rst ? 24'h000000 : o_data;
    end
    else
    begin
      o_valid <= 1'b0;
      if (i_mod_tick)
      begin
        acc <= word_end ? 7'sh00 : acc_next;
        cnt <= cnt + 5'h01;
      end
      if (word_end && settle != SETTLE_WORDS)
        settle <= settle + 2'h1; // RQ23
      else if (word_end)
      begin
        o_data  <= result; // RQ11
        o_valid <= 1'b1;
      end
    end
  end

endmodule : adcdb_channel

// *** hw/adcdb_control.sv ***
// Control, calibration, self test and precharge logic of the converter
//
// Contract
// RQ1 - Gain, offset and phase calibration act only in serial control mode; the code has gain and offset calibration but no phase calibration.
// RQ2 - Five general purpose pins work only in serial control mode.
// RQ3 - Writing the self-test register starts the memory test.
// RQ4 - Status register shows self-test progress and pass or fail.
// RQ5 - Conversions are suspended while the self test runs.
// RQ6 - After the self test, conversion resumes only after a sync pulse.
// RQ7 - Read-only revision register readable in serial control mode.
// RQ8 - Diagnostic mode feeds full-scale, midscale or negative level to channels.
// RQ9 - Each channel filters, then applies gain and offset.
// RQ10 - Control mode taken from the mode select input at power-up.
// RQ11 - Results are 24-bit two's complement, most significant bit first.
// RQ12 - Results saturate at the most positive and most negative codes.
// RQ13 - Pin mode: each power mode fixes its modulator divider.
// RQ14 - Serial mode: power mode and divider set independently.
// RQ15 - Inputs sampled at twice the divided modulator clock rate.
// RQ16 - Precharge buffer active for a fixed early part of each cycle.
// RQ17 - Buffer enable registers store the complement of written bits.
// RQ18 - Reading a buffer enable register returns the stored enables.
// RQ19 - Each channel buffer follows its own enable bit.
// RQ20 - Pin mode keeps every precharge buffer enabled.
// RQ21 - All precharge buffers enabled out of reset.
// RQ22 - Sync bit written zero then one drives the sync output low then high.
// RQ23 - A sync pulse resets all filters; data withheld until settled.
// RQ24 - Busy flag set during self test, cleared when results valid.
// RQ25 - Registers are eight bits, accessed one byte per serial transaction.
`timescale 1ns/10ps
module adcdb_control
  import adcdb_pkg::*;
(
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ctrl_mode_sel,
  input  wire logic [1:0]   i_pin_pwr_mode,
  input  wire logic         i_cs_n,
  input  wire logic         i_sclk,
  input  wire logic         i_sdi,
  output logic              o_sdo,
  input  wire logic [4:0]   i_gpio,
  output logic      [4:0]   o_gpio,
  output logic      [4:0]   o_gpio_oe,
  input  wire logic [7:0]   i_mod_bits,
  output logic              o_mod_clk,
  output logic              o_sample_tick,
  output logic      [7:0]   o_precharge_pos,
  output logic      [7:0]   o_precharge_neg,
  output logic              o_sync_out,
  output logic              o_conv_run,
  output logic      [191:0] o_data,
  output logic      [7:0]   o_data_valid
);

  typedef enum logic [1:0] {BIST_IDLE, BIST_WRITE, BIST_READ} adcdb_bist_e;

  ////////////////////////////////////////////////////////////////////////////
  // Control mode strap

  logic strap_done;
  logic serial_mode;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      strap_done  <= 1'b0;
      serial_mode <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done  <= 1'b1;
      serial_mode <= i_ctrl_mode_sel; // RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial control port: R/W bit, 7-bit address, 8-bit data

  logic        sclk_q;
  logic [3:0]  bit_cnt;
  logic [14:0] shift_in;
  logic        spi_rd;
  logic [7:0]  sdo_shift;
  logic        wr_stb;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_mux;
  wire         sclk_rise = i_sclk && !sclk_q && !i_cs_n;
  wire         sclk_fall = !i_sclk && sclk_q && !i_cs_n;
  wire  [7:0]  hdr       = {shift_in[6:0], i_sdi};
  wire         hdr_end   = sclk_rise && (bit_cnt == 4'h7);
  wire         frame_end = sclk_rise && (bit_cnt == 4'hf);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      sclk_q    <= 1'b0;
      bit_cnt   <= 4'h0;
      shift_in  <= 15'h0000;
      spi_rd    <= 1'b0;
      sdo_shift <= 8'h00;
      o_sdo     <= 1'b0;
      wr_stb    <= 1'b0;
      wr_addr   <= 7'h00;
      wr_data   <= 8'h00;
    end
    else
    begin
      sclk_q <= i_sclk;
      wr_stb <= frame_end && !spi_rd && serial_mode; // RQ25
      if (i_cs_n)
      begin
        bit_cnt <= 4'h0;
        o_sdo   <= 1'b0;
      end
      else if (sclk_rise)
      begin
        shift_in <= {shift_in[13:0], i_sdi};
        bit_cnt  <= bit_cnt + 4'h1;
      end
      if (hdr_end)
      begin
        spi_rd    <= hdr[7];
        wr_addr   <= hdr[6:0];
        sdo_shift <= rd_mux; // RQ7
      end
      if (frame_end)
        wr_data <= hdr;
      if (sclk_fall && bit_cnt[3] && spi_rd && serial_mode)
      begin
        o_sdo     <= sdo_shift[7]; // RQ11
        sdo_shift <= {sdo_shift[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] power_clock;
  logic       sync_bit;
  logic [7:0] self_test;
  logic [7:0] diag_rx;
  logic [7:0] diag_ctl;
  logic [4:0] gpio_dir;
  logic [4:0] gpio_out;
  logic [7:0] buf_low;
  logic [7:0] buf_high;
  logic [7:0] offs [8];
  logic [7:0] gain [8];
  logic [7:0] status;
  wire        wr_cal   = wr_stb && (wr_addr[6:3] == ADDR_OFFS_BASE || wr_addr[6:3] == ADDR_GAIN_BASE);
  wire        sync_evt = wr_stb && (wr_addr == ADDR_SYNC) && wr_data[SYNC_BIT] && !sync_bit;
  wire        bist_go  = wr_stb && (wr_addr == ADDR_SELF_TEST) && wr_data[ST_START_BIT];
  wire  [6:0] ra       = hdr[6:0];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      power_clock <= POWER_CLOCK_RST;
      sync_bit    <= 1'b1;
      self_test   <= 8'h00;
      diag_rx     <= 8'h00;
      diag_ctl    <= 8'h00;
      gpio_dir    <= 5'h00;
      gpio_out    <= 5'h00;
      buf_low     <= BUF_EN_RST; // RQ21
      buf_high    <= BUF_EN_RST; // RQ21
      for (int k = 0; k < 8; k++)
      begin
        offs[k] <= 8'h00;
        gain[k] <= GAIN_UNITY;
      end
    end
    else if (wr_stb)
    begin
      unique case (wr_addr)
        ADDR_POWER_CLOCK: power_clock <= wr_data; // RQ14
        ADDR_SYNC:        sync_bit    <= wr_data[SYNC_BIT]; // RQ22
        ADDR_SELF_TEST:   self_test   <= wr_data;
        ADDR_DIAG_RX:     diag_rx     <= wr_data;
        ADDR_DIAG_CTL:    diag_ctl    <= wr_data;
        ADDR_GPIO_DIR:    gpio_dir    <= wr_data[4:0];
        ADDR_GPIO_OUT:    gpio_out    <= wr_data[4:0];
        ADDR_BUF_LOW:     buf_low     <= ~wr_data; // RQ17
        ADDR_BUF_HIGH:    buf_high    <= ~wr_data; // RQ17
        default:
        begin
          if (wr_cal && wr_addr[6:3] == ADDR_OFFS_BASE)
            offs[wr_addr[2:0]] <= wr_data; // RQ1
          else if (wr_cal)
            gain[wr_addr[2:0]] <= wr_data; // RQ1
        end
      endcase
    end
  end

  // Read selection; unmapped offsets read zero
  assign rd_mux = (ra == ADDR_POWER_CLOCK) ? power_clock :
                  (ra == ADDR_SYNC)        ? {sync_bit, 7'h00} :
                  (ra == ADDR_SELF_TEST)   ? self_test :
                  (ra == ADDR_STATUS)      ? status : // RQ4
                  (ra == ADDR_REVISION)    ? REVISION_ID : // RQ7
                  (ra == ADDR_DIAG_RX)     ? diag_rx :
                  (ra == ADDR_DIAG_CTL)    ? diag_ctl :
                  (ra == ADDR_GPIO_DIR)    ? {3'h0, gpio_dir} :
                  (ra == ADDR_GPIO_OUT)    ? {3'h0, gpio_out} :
                  (ra == ADDR_GPIO_IN)     ? {3'h0, i_gpio} :
                  (ra == ADDR_BUF_LOW)     ? buf_low : // RQ18
                  (ra == ADDR_BUF_HIGH)    ? buf_high : // RQ18
                  (ra[6:3] == ADDR_OFFS_BASE) ? offs[ra[2:0]] :
                  (ra[6:3] == ADDR_GAIN_BASE) ? gain[ra[2:0]] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Memory self test and conversion gating

  adcdb_bist_e bist_state;
  logic [3:0]  bist_addr;
  logic        bist_done;
  logic        bist_fail;
  logic        conv_run;
  logic [7:0]  coef_ram [16];
  wire         bist_busy = (bist_state != BIST_IDLE);
  wire  [7:0]  bist_word = BIST_PATTERN ^ {4'h0, bist_addr};

  assign status = {4'h0, !conv_run, bist_fail, bist_done, bist_busy}; // RQ24

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      bist_state <= BIST_IDLE;
      bist_addr  <= 4'h0;
      bist_done  <= 1'b0;
      bist_fail  <= 1'b0;
      conv_run   <= 1'b1;
    end
    else
    begin
      if (bist_go || bist_busy)
        conv_run <= 1'b0; // RQ5
      else if (sync_evt)
        conv_run <= 1'b1; // RQ6
      unique case (bist_state)
        BIST_IDLE:
          if (bist_go)
          begin
            bist_state <= BIST_WRITE; // RQ3
            bist_addr  <= 4'h0;
            bist_done  <= 1'b0;
            bist_fail  <= 1'b0;
          end
        BIST_WRITE:
        begin
          bist_addr <= bist_addr + 4'h1;
          if (bist_addr == BIST_LAST)
            bist_state <= BIST_READ;
        end
        BIST_READ:
        begin
          bist_addr <= bist_addr + 4'h1;
          if (coef_ram[bist_addr] != bist_word)
            bist_fail <= 1'b1; // RQ4
          if (bist_addr == BIST_LAST)
          begin
            bist_state <= BIST_IDLE;
            bist_done  <= 1'b1; // RQ24
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (bist_state == BIST_WRITE)
      coef_ram[bist_addr] <= bist_word;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode, modulator clock and channels

  logic       mod_tick;
  logic       samp_tick;
  logic       mod_phase;
  logic       pre_win;
  logic       diag_bit;
  wire  [1:0] pwr_eff = serial_mode ? power_clock[PWR_LSB +: 2] : i_pin_pwr_mode; // RQ14
  wire  [1:0] div_eff = serial_mode ? power_clock[1:0] : // RQ14
                        (pwr_eff == PWR_FAST) ? DIV_CODE_4 :
                        (pwr_eff == PWR_MED)  ? DIV_CODE_8 : DIV_CODE_32; // RQ13
  wire        diag_en = serial_mode && diag_ctl[DIAG_EN_BIT];
  wire [15:0] buf_en  = serial_mode ? {buf_high, buf_low} : 16'hffff; // RQ20

  adcdb_mod_timer u_timer (
    .i_ref_clk       (i_ref_clk),
    .i_rst           (i_rst),
    .i_div_code      (div_eff),
    .i_pwr_mode      (pwr_eff),
    .o_mod_tick      (mod_tick),
    .o_sample_tick   (samp_tick),
    .o_mod_phase     (mod_phase),
    .o_precharge_win (pre_win)
  );

  // Midscale is an alternating bit stream
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      diag_bit <= 1'b0;
    else if (diag_ctl[1:0] == DIAG_MID)
      diag_bit <= mod_tick ? !diag_bit : diag_bit; // RQ8
    else
      diag_bit <= (diag_ctl[1:0] == DIAG_POS_FS); // RQ8
  end

  for (genvar k = 0; k < 8; k++)
  begin : g_chan
    wire ch_bit = (diag_en && diag_rx[k]) ? diag_bit : i_mod_bits[k]; // RQ8
    adcdb_channel u_chan (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_mod_tick(mod_tick),
      .i_mod_bit (ch_bit),
      .i_sync    (sync_evt), // RQ23
      .i_run     (conv_run),
      .i_gain    (serial_mode ? gain[k] : GAIN_UNITY), // RQ1
      .i_offset  (serial_mode ? $signed(offs[k]) : 8'sh00), // RQ1
      .o_data    (o_data[24*k +: 24]),
      .o_valid   (o_data_valid[k])
    );
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_mod_clk       <= 1'b0;
      o_sample_tick   <= 1'b0;
      o_precharge_pos <= 8'h00;
      o_precharge_neg <= 8'h00;
      o_sync_out      <= 1'b1;
      o_conv_run      <= 1'b1;
      o_gpio          <= 5'h00;
      o_gpio_oe       <= 5'h00;
    end
    else
    begin
      o_mod_clk     <= mod_phase;
      o_sample_tick <= samp_tick; // RQ15
      for (int k = 0; k < 8; k++)
      begin
        o_precharge_pos[k] <= pre_win && buf_en[2*k]; // RQ19
        o_precharge_neg[k] <= pre_win && buf_en[2*k+1]; // RQ19
      end
      o_sync_out <= sync_bit; // RQ22
      o_conv_run <= conv_run;
      o_gpio     <= serial_mode ? gpio_out : 5'h00; // RQ2
      o_gpio_oe  <= serial_mode ? gpio_dir : 5'h00; // RQ2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_pin_no_gpio: assert property (strap_done && !serial_mode |=> o_gpio_oe == 5'h00) // RQ2
    else $error("gpio driven in pin control mode");
  a_bist_starts: assert property (bist_go && !bist_busy |=> bist_busy ##16 bist_state == BIST_READ) // RQ3
    else $error("self test did not start on write");
  a_bist_length: assert property ($rose(bist_busy) |-> bist_busy [*8] ##25 $fell(bist_busy)) // RQ24
    else $error("self test length wrong");
  a_status_busy: assert property (bist_state == BIST_READ && bist_addr == BIST_LAST |=> status[1:0] == 2'h2) // RQ4
    else $error("status does not show self test state");
  a_run_suspend: assert property (bist_busy |=> !conv_run && !o_data_valid[0]) // RQ5
    else $error("conversion running during self test");
  a_resume_sync: assert property ($rose(conv_run) |-> $past(sync_evt)) // RQ6
    else $error("conversion resumed without sync");
  a_buf_invert: assert property (wr_stb && wr_addr == ADDR_BUF_LOW |=> buf_low == ~$past(wr_data)) // RQ17
    else $error("buffer enable not stored inverted");
  a_pin_buf_on: assert property (strap_done && !serial_mode && pre_win |=> o_precharge_pos == 8'hff) // RQ20
    else $error("precharge buffer off in pin control mode");
  a_sync_low: assert property (wr_stb && wr_addr == ADDR_SYNC && !wr_data[SYNC_BIT] |=> ##1 !o_sync_out) // RQ22
    else $error("sync output not driven low");
  a_pin_div: assert property (!serial_mode && pwr_eff == PWR_FAST |-> div_eff == DIV_CODE_4) // RQ13
    else $error("pin mode divider not tied to power mode");

endmodule : adcdb_control

// *** verif/adcdb_host.sv ***
// Host model driving the serial control port
`timescale 1ns/10ps
module adcdb_host (
  input  wire logic i_ref_clk,
  input  wire logic i_sdo,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end
  task automatic half(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : half
  // One 16-bit frame, one byte of data, read bits taken at rises
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      o_sdi = f[i];
      half(3);
      if (i < 8)
        rd[i] = i_sdo;
      o_sclk = 1'b1;
      half(3);
      o_sclk = 1'b0;
    end
    half(3);
    o_cs_n = 1'b1;
    // Released data line shows no stale value
    o_sdi  = ~o_sdi;
    half(3);
  endtask : xfer
endmodule : adcdb_host

// *** verif/test_adc_diag_buffer_control.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module test_adc_diag_buffer_control
  import adcdb_pkg::*;
;
  logic         i_ref_clk, i_rst, i_ctrl_mode_sel, frc;
  logic [1:0]   i_pin_pwr_mode;
  logic [4:0]   i_gpio;
  logic [7:0]   i_mod_bits, fv, rv, acc, acn;
  wire          cs_n, sclk, sdi, o_sdo, o_mod_clk, o_sample_tick, o_sync_out, o_conv_run;
  wire  [4:0]   o_gpio, o_gpio_oe;
  wire  [7:0]   o_precharge_pos, o_precharge_neg, o_data_valid;
  wire  [191:0] o_data;
  int           mismatches, checked;

  adcdb_control dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ctrl_mode_sel(i_ctrl_mode_sel),
    .i_pin_pwr_mode(i_pin_pwr_mode), .i_cs_n(cs_n), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(o_sdo),
    .i_gpio(i_gpio), .o_gpio(o_gpio), .o_gpio_oe(o_gpio_oe), .i_mod_bits(i_mod_bits),
    .o_mod_clk(o_mod_clk), .o_sample_tick(o_sample_tick), .o_precharge_pos(o_precharge_pos),
    .o_precharge_neg(o_precharge_neg), .o_sync_out(o_sync_out), .o_conv_run(o_conv_run),
    .o_data(o_data), .o_data_valid(o_data_valid));
  adcdb_host host (.i_ref_clk(i_ref_clk), .i_sdo(o_sdo), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_sdi(sdi));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) i_mod_bits <= #1 frc ? fv : 8'($urandom);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic hang();
    mismatches++;
    $display("mismatch at %0t: wait ran out", $time);
    end_sim();
  endtask : hang
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task automatic rst(input logic m);
    i_ctrl_mode_sel = m;
    i_rst = 1'b1;
    tick(5);
    i_rst = 1'b0;
    tick(3);
  endtask : rst
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b0, a, d}, rv);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host.xfer({1'b1, a, 8'h00}, d);
  endtask : rd
  // One modulator period: length, sample ticks, precharge cycles
  task automatic meas(input int per, input int win);
    int   n, t, w;
    logic p;
    n = 0;
    t = 0;
    w = 0;
    p = 1'b1;
    while (!(p === 1'b0 && o_mod_clk === 1'b1))
    begin
      p = o_mod_clk;
      tick(1);
      if (++n > 99)
        hang();
    end
    n = 0;
    do
    begin
      p = o_mod_clk;
      tick(1);
      n++;
      t += int'(o_sample_tick);
      w += int'(o_precharge_pos[0]);
    end while (!(p === 1'b0 && o_mod_clk === 1'b1) && n < 99);
    check(24'(n), 24'(per));
    check(24'(t), 24'd2);
    check(24'(w), 24'(win));
  endtask : meas
  task automatic valid_wait(output int n);
    n = 0;
    tick(1);
    while (o_data_valid[0] !== 1'b1)
    begin
      if (++n > 999)
        hang();
      tick(1);
    end
  endtask : valid_wait
  task automatic sat(input logic [7:0] v, input logic [23:0] e0, input logic [23:0] e7);
    int n;
    frc = 1'b1;
    fv  = v;
    repeat (3) valid_wait(n);
    check(o_data[23:0], e0);
    check(o_data[191:168], e7);
    frc = 1'b0;
  endtask : sat
  function automatic logic [7:0] pm(input logic [15:0] e, input int s);
    for (int k = 0; k < 8; k++)
      pm[k] = e[2*k+s];
  endfunction : pm

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] d, lo, hi;
    int         n;
    i_rst = 1'b1;
    i_ctrl_mode_sel = 1'b1;
    i_pin_pwr_mode = PWR_FAST;
    i_gpio = 5'h00;
    frc = 1'b0;
    fv = 8'h00;
    mismatches = 0;
    checked = 0;
    d = 8'($urandom(32'h4149a4f3));
    rst(1'b1);
    check(o_sync_out, 1'b1);
    rd(ADDR_BUF_LOW, d);
    check(d, BUF_EN_RST);
    rd(ADDR_BUF_HIGH, d);
    check(d, BUF_EN_RST);
    rd(ADDR_REVISION, d);
    check(d, REVISION_ID);
    wr(ADDR_POWER_CLOCK, {2'h0, PWR_MED, 2'h0, DIV_CODE_8});
    meas(8, PRE_MED_CYC);
    wr(ADDR_POWER_CLOCK, {2'h0, PWR_LOW, 2'h0, DIV_CODE_32});
    meas(32, PRE_LOW_CYC);
    wr(ADDR_POWER_CLOCK, {2'h0, PWR_FAST, 4'h2});
    meas(16, PRE_FAST_CYC);
    wr(ADDR_POWER_CLOCK, POWER_CLOCK_RST);
    meas(4, PRE_FAST_CYC);
    // Saturation, then gain and offset on channel 0 only
    sat(8'hff, CODE_POS_FS, CODE_POS_FS);
    sat(8'h00, CODE_NEG_FS, CODE_NEG_FS);
    wr(7'h28, 8'h40);
    wr(7'h20, 8'h10);
    sat(8'hff, 24'h401000, CODE_POS_FS);
    wr(7'h28, GAIN_UNITY);
    wr(7'h20, 8'h00);
    // Diagnostic levels on channel 0 against the opposite bit stream
    wr(ADDR_DIAG_RX, 8'h01);
    wr(ADDR_DIAG_CTL, {6'h20, DIAG_POS_FS});
    sat(8'h00, CODE_POS_FS, CODE_NEG_FS);
    wr(ADDR_DIAG_CTL, {6'h20, DIAG_MID});
    sat(8'hff, 24'h000000, CODE_POS_FS);
    wr(ADDR_DIAG_CTL, 8'h83);
    sat(8'hff, CODE_NEG_FS, CODE_POS_FS);
    wr(ADDR_DIAG_CTL, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      lo = (k == 0) ? 8'h01 : 8'($urandom);
      hi = 8'($urandom);
      wr(ADDR_BUF_LOW, lo);
      wr(ADDR_BUF_HIGH, hi);
      rd(ADDR_BUF_LOW, d);
      check(d, 8'(~lo));
      rd(ADDR_BUF_HIGH, d);
      check(d, 8'(~hi));
      acc = 8'h00;
      acn = 8'h00;
      repeat (8)
      begin
        tick(1);
        acc |= o_precharge_pos;
        acn |= o_precharge_neg;
      end
      check(acc, pm(~{hi, lo}, 0));
      check(acn, pm(~{hi, lo}, 1));
    end
    wr(7'h13, 8'h5a);
    rd(7'h13, d);
    check(d, 8'h00);
    wr(ADDR_REVISION, 8'h00);
    rd(ADDR_REVISION, d);
    check(d, REVISION_ID);
    wr(ADDR_SYNC, 8'h00);
    check(o_sync_out, 1'b0);
    wr(ADDR_SYNC, 8'h80);
    check(o_sync_out, 1'b1);
    wr(ADDR_SELF_TEST, 8'h01);
    check(o_conv_run, 1'b0);
    rd(ADDR_STATUS, d);
    check(d[3:0], 4'ha);
    acc = 8'h00;
    repeat (300)
    begin
      tick(1);
      acc |= o_data_valid;
    end
    check(acc, 8'h00);
    check(o_conv_run, 1'b0);
    wr(ADDR_SYNC, 8'h00);
    wr(ADDR_SYNC, 8'h80);
    check(o_conv_run, 1'b1);
    valid_wait(n);
    check(n > 200, 1'b1);
    wr(ADDR_GPIO_DIR, 8'h1f);
    wr(ADDR_GPIO_OUT, 8'h15);
    check(o_gpio_oe, 5'h1f);
    check(o_gpio, 5'h15);
    i_gpio = 5'($urandom);
    rd(ADDR_GPIO_IN, d);
    check(d[4:0], i_gpio);
    // Pin control: frames ignored, buffers forced on
    rst(1'b0);
    check(o_gpio_oe, 5'h00);
    wr(ADDR_BUF_LOW, 8'hff);
    i_pin_pwr_mode = PWR_LOW;
    tick(40);
    meas(32, PRE_LOW_CYC);
    i_pin_pwr_mode = PWR_MED;
    tick(40);
    meas(8, PRE_MED_CYC);
    rd(ADDR_REVISION, d);
    check(d, 8'h00);
    end_sim();
  end
endmodule : test_adc_diag_buffer_control
